/* File: ams_adc_model.sv */
module ams_adc_model (
    input wire logic sys_clk,
    input wire logic adc_start,
    output logic [15:0] adc_sample
);
    timeunit 1ns;
    timeprecision 1ns;
    // Each start presents a new code, so every result shows its conversion.
    initial begin
        adc_sample = 16'hA500;
        forever begin
            @(posedge sys_clk);
            if (adc_start) begin
                adc_sample <= adc_sample + 16'h0001;
            end
        end
    end
endmodule

/* File: ams_cfg.svh */
`ifndef AMS_CFG_SVH
`define AMS_CFG_SVH

`define AMS_AW 8
`define AMS_DW 16
`define AMS_CW 11

`define AMS_OFS_CTRL 8'h00
`define AMS_OFS_RESULT 8'h02
`define AMS_OFS_STATUS 8'h05
`define AMS_OFS_CONVERT 8'h07
`define AMS_OFS_VECTOR 8'h09

`define AMS_BIT_INT_EN 6
`define AMS_BIT_AUTO 7
`define AMS_BIT_PIPE 8
`define AMS_BIT_DIFF 9

`define AMS_CLK_NS 20
`define AMS_T_SETTLE_NORM_NS 2500
`define AMS_T_SETTLE_AUTO_NS 10000
`define AMS_T_CONV_NORM_NP_NS 22000
`define AMS_T_CONV_NORM_P_NS 12000
`define AMS_T_CONV_AUTO_NP_NS 22000
`define AMS_T_CONV_AUTO_P_NS 10000

`define AMS_CYC(ns) ((ns + `AMS_CLK_NS - 1) / `AMS_CLK_NS)

`endif

/* File: ams_pkg.sv */
`include "ams_cfg.svh"

package ams_pkg;
    typedef enum logic {AMS_IDLE, AMS_CONV} ams_conv_e;

    typedef struct packed {
        logic [9:0] ctrl;
        logic [6:0] vec_hi;
        logic [`AMS_DW-1:0] result;
        logic [`AMS_DW-1:0] prev;
        logic [`AMS_DW-1:0] smp1;
        logic [`AMS_DW-1:0] smp2;
        logic [`AMS_CW-1:0] settle_cnt;
        logic [`AMS_CW-1:0] conv_cnt;
        logic settle;
        logic settle_q;
        ams_conv_e cst;
        logic auto_pend;
        logic busy_q;
        logic irq_data;
        logic irq_settle;
        logic start;
        logic [`AMS_DW-1:0] rdata;
        logic [`AMS_CW-1:0] chk_settle_age;
        logic [`AMS_CW-1:0] chk_conv_age;
        logic [1:0] chk_conv_mode;
    } ams_state_s;
endpackage

/* File: ams_sequencer.sv */
// Operation
// - Bit 7 picks normal or automatic settling.
// - Bit 8 picks direct or pipelined result.
// - Control write, bit 7 clear: normal mode.
// - Control write, bit 7 set: automatic mode.
// - Settle flag high until settling interval ends.
// - Settling of next channel overlaps conversion.
// - Busy high during conversion; low means result valid.
// - Normal mode raises settle and data interrupts.
// - Normal direct: current result, 22 us cycle.
// - Normal pipelined: 12 us, 14.5 us on change.
// - Automatic mode starts conversion after settling.
// - Automatic busy covers select, settling and conversion.
// - Automatic busy fall: result readable, one interrupt.
// - Automatic direct: current result, 32 us cycle.
// - Automatic pipelined: previous result, 20 us cycle.
// - Trigger writes while busy are ignored.
// - Data interrupt on busy fall, line 0.
// - Settle-fall interrupt on line 1, normal only.
// - Vector bit 0 tells settle from data source.
`include "ams_cfg.svh"
module ams_sequencer (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [`AMS_AW-1:0] addr,
    input wire logic [`AMS_DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [`AMS_DW-1:0] rdata,
    input wire logic int_ack,
    output logic intreq_data_n,
    output logic intreq_settle_n,
    input wire logic [`AMS_DW-1:0] adc_sample,
    output logic adc_start,
    output logic [3:0] chan_sel,
    output logic [1:0] gain_sel,
    output logic diff_mode
);
    localparam logic [`AMS_CW-1:0] SETTLE_NORM =
        `AMS_CW'(`AMS_CYC(`AMS_T_SETTLE_NORM_NS));
    localparam logic [`AMS_CW-1:0] SETTLE_AUTO =
        `AMS_CW'(`AMS_CYC(`AMS_T_SETTLE_AUTO_NS));
    localparam logic [`AMS_CW-1:0] CONV_NORM_NP =
        `AMS_CW'(`AMS_CYC(`AMS_T_CONV_NORM_NP_NS));
    localparam logic [`AMS_CW-1:0] CONV_NORM_P =
        `AMS_CW'(`AMS_CYC(`AMS_T_CONV_NORM_P_NS));
    localparam logic [`AMS_CW-1:0] CONV_AUTO_NP =
        `AMS_CW'(`AMS_CYC(`AMS_T_CONV_AUTO_NP_NS));
    localparam logic [`AMS_CW-1:0] CONV_AUTO_P =
        `AMS_CW'(`AMS_CYC(`AMS_T_CONV_AUTO_P_NS));
    localparam logic [`AMS_CW-1:0] ONE = `AMS_CW'(1);
    localparam logic [`AMS_CW-1:0] ZERO = '0;
    localparam logic [`AMS_CW-1:0] AGE_MAX = '1;

    ams_pkg::ams_state_s q;
    ams_pkg::ams_state_s n;

    logic ctrl_wr;
    logic conv_wr;
    logic auto_mode;
    logic pipe_mode;
    logic int_en;
    logic busy;
    logic fell_busy;
    logic fell_settle;
    logic go;
    logic [`AMS_CW-1:0] conv_len;

    assign ctrl_wr = wr && addr == `AMS_OFS_CTRL;
    assign conv_wr = wr && addr == `AMS_OFS_CONVERT;
    assign auto_mode = q.ctrl[`AMS_BIT_AUTO];
    assign pipe_mode = q.ctrl[`AMS_BIT_PIPE];
    assign int_en = q.ctrl[`AMS_BIT_INT_EN];
    // In automatic mode busy also covers the pending settling phase.
    assign busy = q.cst == ams_pkg::AMS_CONV || q.auto_pend;
    assign fell_busy = q.busy_q && !busy;
    assign fell_settle = q.settle_q && !q.settle;

    always_comb begin
        unique case ({auto_mode, pipe_mode})
            2'b00: conv_len = CONV_NORM_NP;
            2'b01: conv_len = CONV_NORM_P;
            2'b10: conv_len = CONV_AUTO_NP;
            2'b11: conv_len = CONV_AUTO_P;
        endcase
    end

    always_comb begin
        n = q;
        n.start = 1'b0;
        n.rdata = 16'h0000;
        // The sample bus is registered every cycle into smp1 and smp2; smp2 is taken at conversion end.
        n.smp1 = adc_sample;
        n.smp2 = q.smp1;
        n.busy_q = busy;
        n.settle_q = q.settle;
        go = 1'b0;

        if (q.settle) begin
            n.settle_cnt = q.settle_cnt - ONE;
            if (q.settle_cnt == ONE) begin
                n.settle = 1'b0;
            end
        end

        // Assertion helpers: ages since the last control write and start.
        // They stop at the top so a long idle spell cannot wrap them.
        if (q.chk_settle_age != ZERO && q.chk_settle_age != AGE_MAX) begin
            n.chk_settle_age = q.chk_settle_age + ONE;
        end
        if (q.chk_conv_age != ZERO && q.chk_conv_age != AGE_MAX) begin
            n.chk_conv_age = q.chk_conv_age + ONE;
        end

        unique case (q.cst)
            ams_pkg::AMS_IDLE: begin
                if (q.auto_pend) begin
                    go = !q.settle;
                end else begin
                    go = conv_wr && !auto_mode;
                end
            end
            ams_pkg::AMS_CONV: begin
                n.conv_cnt = q.conv_cnt - ONE;
                if (q.conv_cnt == ONE) begin
                    n.cst = ams_pkg::AMS_IDLE;
                    n.prev = q.smp2;
                    if (!pipe_mode) begin
                        n.result = q.smp2;
                    end
                end
            end
        endcase

        if (go) begin
            n.cst = ams_pkg::AMS_CONV;
            n.conv_cnt = conv_len;
            n.start = 1'b1;
            n.auto_pend = 1'b0;
            n.chk_conv_age = ONE;
            n.chk_conv_mode = {auto_mode, pipe_mode};
            if (pipe_mode) begin
                n.result = q.prev;
            end
        end

        // A control write restarts settling even mid-conversion.
        if (ctrl_wr) begin
            n.ctrl = wdata[9:0];
            n.settle = 1'b1;
            n.chk_settle_age = ONE;
            if (wdata[`AMS_BIT_AUTO]) begin
                n.settle_cnt = SETTLE_AUTO;
                n.auto_pend = 1'b1;
            end else begin
                n.settle_cnt = SETTLE_NORM;
                n.auto_pend = 1'b0;
            end
        end
        if (wr && addr == `AMS_OFS_VECTOR) begin
            n.vec_hi = wdata[7:1];
        end

        // Acknowledge clears first, so a same-cycle event still wins.
        if (int_ack) begin
            n.rdata = {8'h00, q.vec_hi, !q.irq_data && q.irq_settle};
            if (q.irq_data) begin
                n.irq_data = 1'b0;
            end else begin
                n.irq_settle = 1'b0;
            end
        end else if (rd) begin
            case (addr)
                `AMS_OFS_CTRL: n.rdata = {6'h00, q.ctrl};
                `AMS_OFS_RESULT: n.rdata = q.result;
                `AMS_OFS_STATUS: n.rdata = {14'h0000, busy, q.settle};
                `AMS_OFS_VECTOR: n.rdata = {8'h00, q.vec_hi, 1'b0};
                default: n.rdata = 16'h0000;
            endcase
        end
        if (fell_busy && int_en) begin
            n.irq_data = 1'b1;
        end
        if (fell_settle && !auto_mode && int_en) begin
            n.irq_settle = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign rdata = q.rdata;
    assign adc_start = q.start;
    assign chan_sel = q.ctrl[3:0];
    assign gain_sel = q.ctrl[5:4];
    assign diff_mode = q.ctrl[`AMS_BIT_DIFF];
    assign intreq_data_n = !q.irq_data;
    assign intreq_settle_n = !q.irq_settle;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    sequence s_norm_ctrl;
        ctrl_wr && !wdata[`AMS_BIT_AUTO];
    endsequence

    sequence s_settle_run;
        q.settle[*8];
    endsequence

    sequence s_norm_trig;
        conv_wr && !auto_mode && !busy;
    endsequence

    a_trig_when_busy: assert property (
        conv_wr && q.cst == ams_pkg::AMS_CONV |=> !adc_start)
        else $error("trigger accepted while busy");

    a_norm_trig_start: assert property (
        s_norm_trig |=> adc_start && busy ##1 busy[*6])
        else $error("normal trigger did not start conversion");

    a_settle_flag_run: assert property (
        s_norm_ctrl |=> s_settle_run)
        else $error("settle flag dropped too early");

    a_settle_ends: assert property (
        !auto_mode && q.chk_settle_age > SETTLE_NORM |-> !q.settle)
        else $error("settle flag stuck after interval");

    a_settle_held: assert property (
        !auto_mode && q.chk_settle_age != ZERO &&
        q.chk_settle_age <= SETTLE_NORM |-> q.settle)
        else $error("settle flag low inside interval");

    a_auto_settle_end: assert property (
        auto_mode && q.chk_settle_age > SETTLE_AUTO |-> !q.settle)
        else $error("automatic settling ran too long");

    a_auto_ctrl_busy: assert property (
        ctrl_wr && wdata[`AMS_BIT_AUTO] |=> busy && q.settle)
        else $error("automatic write did not set busy");

    a_auto_self_start: assert property (
        q.auto_pend && !q.settle && q.cst == ams_pkg::AMS_IDLE
        |=> adc_start)
        else $error("automatic conversion not started");

    a_auto_no_trig: assert property (
        q.cst == ams_pkg::AMS_IDLE && !q.auto_pend && auto_mode
        |=> !adc_start)
        else $error("automatic mode started without control write");

    a_pipe_prev_load: assert property (
        adc_start && pipe_mode |-> q.result == $past(q.prev))
        else $error("pipelined start did not load previous result");

    a_direct_load: assert property (
        $fell(q.cst == ams_pkg::AMS_CONV) && !pipe_mode
        |-> q.result == $past(q.smp2))
        else $error("direct mode did not load current result");

    a_data_irq_rise: assert property (
        fell_busy && int_en && !int_ack |=> !intreq_data_n)
        else $error("data interrupt not raised");

    a_settle_irq_auto: assert property (
        fell_settle && auto_mode && !q.irq_settle |=> intreq_settle_n)
        else $error("settle interrupt raised in automatic mode");

    a_conv_len_np: assert property (
        q.chk_conv_mode == 2'b00 && q.chk_conv_age != ZERO &&
        q.chk_conv_age <= CONV_NORM_NP |-> q.cst == ams_pkg::AMS_CONV)
        else $error("normal direct conversion ended early");

    a_conv_end_np: assert property (
        q.chk_conv_mode == 2'b00 && q.chk_conv_age == CONV_NORM_NP + ONE
        |-> q.cst == ams_pkg::AMS_IDLE)
        else $error("normal direct conversion ran too long");

    a_conv_end_p: assert property (
        q.chk_conv_mode == 2'b01 && q.chk_conv_age == CONV_NORM_P + ONE
        |-> q.cst == ams_pkg::AMS_IDLE)
        else $error("normal pipelined conversion length wrong");

    a_conv_end_an: assert property (
        q.chk_conv_mode == 2'b10 && q.chk_conv_age == CONV_AUTO_NP + ONE
        |-> q.cst == ams_pkg::AMS_IDLE)
        else $error("automatic direct conversion length wrong");

    a_conv_end_ap: assert property (
        q.chk_conv_mode == 2'b11 && q.chk_conv_age == CONV_AUTO_P + ONE
        |-> q.cst == ams_pkg::AMS_IDLE)
        else $error("automatic pipelined conversion length wrong");

    a_vec_source: assert property (
        int_ack && !q.irq_data && q.irq_settle |=> rdata[0])
        else $error("vector bit 0 not set for settle source");
endmodule

/* File: tb_ams_sequencer.sv */
`include "ams_cfg.svh"

module tb_ams_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic int_ack = 1'b0;
    logic [15:0] rdata;
    logic [15:0] adc_sample;
    logic [15:0] d;
    logic adc_start;
    logic intreq_data_n;
    logic intreq_settle_n;
    logic diff_mode;
    logic [3:0] chan_sel;
    logic [1:0] gain_sel;
    int mismatches = 0;
    int n_checks = 0;
    int starts = 0;

    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (adc_start) begin
            starts <= starts + 1;
        end
    end

    ams_sequencer u_dut (.sys_clk, .srst, .addr, .wdata, .wr, .rd, .rdata,
        .int_ack, .intreq_data_n, .intreq_settle_n, .adc_sample, .adc_start,
        .chan_sel, .gain_sel, .diff_mode);
    ams_adc_model u_adc (.sys_clk, .adc_start, .adc_sample);

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task wr_reg(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    // Read data stand for one cycle only, so they are taken mid-cycle.
    task rd_reg(input logic [7:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        d = rdata;
    endtask
    task ack();
        @(posedge sys_clk);
        int_ack <= 1'b1;
        @(posedge sys_clk);
        int_ack <= 1'b0;
        @(negedge sys_clk);
        d = rdata;
    endtask
    task final_report();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        cyc(20000);
        mismatches++;
        final_report();
    end

    initial begin
        cyc(20);
        srst <= 1'b0;
        rd_reg(`AMS_OFS_STATUS);
        chk(d, 16'h0000);
        rd_reg(8'h0C);
        chk(d, 16'h0000);
        // The converter wakes in an unknown state: two runs are discarded.
        repeat (2) begin
            wr_reg(`AMS_OFS_CONVERT, 16'h0000);
            cyc(1105);
        end
        wr_reg(`AMS_OFS_VECTOR, 16'h0060);
        rd_reg(`AMS_OFS_VECTOR);
        chk(d, 16'h0060);
        wr_reg(`AMS_OFS_CTRL, 16'h0045);
        rd_reg(`AMS_OFS_STATUS);
        chk(d, 16'h0001);
        chk({12'h000, chan_sel}, 16'h0005);
        cyc(130);
        rd_reg(`AMS_OFS_STATUS);
        chk(d, 16'h0000);
        chk({15'h0000, intreq_settle_n}, 16'h0000);
        ack();
        chk(d, 16'h0061);
        chk({15'h0000, intreq_settle_n}, 16'h0001);
        // The host waited for settling above before this trigger.
        wr_reg(`AMS_OFS_CONVERT, 16'h0000);
        wr_reg(`AMS_OFS_CONVERT, 16'h0000);
        wr_reg(`AMS_OFS_CTRL, 16'h0266);
        rd_reg(`AMS_OFS_STATUS);
        chk(d, 16'h0003);
        chk({14'h0000, gain_sel}, 16'h0002);
        chk({15'h0000, diff_mode}, 16'h0001);
        rd_reg(`AMS_OFS_CTRL);
        chk(d, 16'h0266);
        cyc(1100);
        rd_reg(`AMS_OFS_STATUS);
        chk(d, 16'h0000);
        rd_reg(`AMS_OFS_RESULT);
        chk(d, 16'hA503);
        chk(starts[15:0], 16'h0003);
        chk({15'h0000, intreq_data_n}, 16'h0000);
        ack();
        chk(d, 16'h0060);
        ack();
        chk(d, 16'h0061);
        wr_reg(`AMS_OFS_CTRL, 16'h0105);
        cyc(130);
        wr_reg(`AMS_OFS_CONVERT, 16'h0000);
        rd_reg(`AMS_OFS_RESULT);
        chk(d, 16'hA503);
        cyc(575);
        rd_reg(`AMS_OFS_STATUS);
        chk(d, 16'h0002);
        cyc(30);
        rd_reg(`AMS_OFS_STATUS);
        chk(d, 16'h0000);
        chk({15'h0000, intreq_data_n}, 16'h0001);
        // Same channel and gain, so the trigger follows without polling.
        wr_reg(`AMS_OFS_CONVERT, 16'h0000);
        cyc(620);
        rd_reg(`AMS_OFS_RESULT);
        chk(d, 16'hA504);
        wr_reg(`AMS_OFS_CTRL, 16'h00C5);
        rd_reg(`AMS_OFS_STATUS);
        chk(d, 16'h0003);
        cyc(480);
        chk(starts[15:0], 16'h0005);
        cyc(40);
        chk(starts[15:0], 16'h0006);
        rd_reg(`AMS_OFS_STATUS);
        chk(d, 16'h0002);
        cyc(1100);
        rd_reg(`AMS_OFS_STATUS);
        chk(d, 16'h0000);
        rd_reg(`AMS_OFS_RESULT);
        chk(d, 16'hA506);
        chk({15'h0000, intreq_settle_n}, 16'h0001);
        ack();
        chk(d, 16'h0060);
        wr_reg(`AMS_OFS_CONVERT, 16'h0000);
        wr_reg(`AMS_OFS_CTRL, 16'h01C5);
        cyc(1020);
        rd_reg(`AMS_OFS_STATUS);
        chk(d, 16'h0000);
        rd_reg(`AMS_OFS_RESULT);
        chk(d, 16'hA506);
        chk(starts[15:0], 16'h0007);
        final_report();
    end
endmodule
